// File: inc/config_cycle_router_defines.svh
// Offsets, field positions, reset values and timing for the config router.
// Assumes host I/O addresses are 16-bit byte addresses.
`ifndef CONFIG_CYCLE_ROUTER_DEFINES_SVH
`define CONFIG_CYCLE_ROUTER_DEFINES_SVH

`define CCR_ADDR_PORT_IO   16'h0cf8
`define CCR_DATA_WINDOW_IO 16'h0cfc
`define CCR_ADDR_RST       32'h0000_0000
`define CCR_ADDR_WR_MASK   32'h80ff_fffc
`define CCR_ENABLE_BIT     31
`define CCR_BUS_HI         23
`define CCR_BUS_LO         16
`define CCR_DEV_HI         15
`define CCR_DEV_LO         11
`define CCR_FUNC_HI        10
`define CCR_FUNC_LO        8
`define CCR_REG_HI         7
`define CCR_REG_LO         2
`define CCR_ROOT_BUS       8'h00
`define CCR_DEV_HOST       5'h00
`define CCR_DEV_AGP        5'h01
`define CCR_DEV_GFX        5'h02
`define CCR_FUNC_ZERO      3'h0
`define CCR_FULL_DWORD     4'hf
`define CCR_ABORT_DATA     32'hffff_ffff
`define CCR_CLK_PERIOD_NS  10
`define CCR_ACK_TIMEOUT_NS 10000
`define CCR_ACK_TIMEOUT_CYC (`CCR_ACK_TIMEOUT_NS / `CCR_CLK_PERIOD_NS)

`endif

// File: inc/config_cycle_router_pkg.sv
// Types shared by the configuration cycle router and its decoder.
// Constants live in the defines header.
package config_cycle_router_pkg;

  typedef enum logic [2:0] {
    TGT_INT   = 3'h0,
    TGT_HUB0  = 3'h1,
    TGT_HUB1  = 3'h2,
    TGT_AGP0  = 3'h3,
    TGT_AGP1  = 3'h4,
    TGT_ABORT = 3'h5
  } target_t;

  typedef enum logic [1:0] {
    HUB_IO   = 2'h0,
    HUB_CFG0 = 2'h1,
    HUB_CFG1 = 2'h2
  } hub_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } state_t;

  typedef struct packed {
    state_t    st;
    target_t   tgt;
    logic [31:0] addr_port;
    logic        io_rdy;
    logic        io_ack;
    logic        io_abort;
    logic [31:0] io_rdata;
    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [2:0]  func;
    logic [5:0]  regn;
    logic [3:0]  be;
    logic        wr;
    logic [31:0] wdata;
    logic        int_req;
    logic [1:0]  int_dev;
    logic        hub_req;
    hub_kind_t   hub_kind;
    logic [15:0] hub_addr;
    logic        agp_req;
    logic        agp_type1;
    logic [15:0] agp_idsel;
    logic [10:0] tmo;
  } router_state_t;

endpackage

// File: core/lane_mask.sv
// Keeps only the byte lanes named by a byte enable, zeroing the rest.
// Lane 0 is the lowest byte address, so fields stay little-endian.
`timescale 1ns/1ps
module lane_mask #(
  parameter int LANES = 4
) (
  // Lane selection
  input  wire logic [LANES-1:0]   be,
  // Data
  input  wire logic [8*LANES-1:0] din,
  output      logic [8*LANES-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      assign dout[8*i +: 8] = be[i] ? din[8*i +: 8] : 8'h00;
    end
  endgenerate
endmodule

// File: core/cfg_target_decode.sv
// Chooses where a configuration cycle goes from bus, device and function.
// Assumes secondary and subordinate bus numbers come from the AGP bridge.
`timescale 1ns/1ps
`include "config_cycle_router_defines.svh"
module cfg_target_decode
  import config_cycle_router_pkg::*;
(
  // Address fields
  input  wire logic [7:0] bus,
  input  wire logic [4:0] dev,
  input  wire logic [2:0] func,
  // Bridge window
  input  wire logic [7:0] sec_bus,
  input  wire logic [7:0] sub_bus,
  // Result
  output      config_cycle_router_pkg::target_t tgt
);
  always_comb begin
    if (bus == `CCR_ROOT_BUS) begin
      if (dev <= `CCR_DEV_GFX) begin
        tgt = (func == `CCR_FUNC_ZERO) ? TGT_INT : TGT_ABORT;
      end else begin
        tgt = TGT_HUB0;
      end
    end else if (bus == sec_bus) begin
      tgt = TGT_AGP0;
    end else if (bus > sec_bus && bus <= sub_bus) begin
      tgt = TGT_AGP1;
    end else begin
      tgt = TGT_HUB1;
    end
  end
endmodule

// File: core/config_cycle_router.sv
// Configuration cycle router: address port, data window and cycle routing.
// Assumes the host issues one I/O request at a time while io_ready is high,
// and that each far side answers a held request with a one-cycle ack.
//
// Behaviour
// - Decode bus bits 23:16 and device; bus zero means the root bus.
// - Root bus device 0 is host bridge, device 1 is AGP; fixed.
// - Root bus device 2 goes to internal graphics, never the hub link.
// - Cycles to the three internal devices complete inside, not on hub.
// - Root bus devices 3 to 31 go over the hub link as Type 0.
// - Bus zero with no internal target gives a hub link Type 0 cycle.
// - Nonzero bus equal to secondary bus gives AGP Type 0.
// - Bus above secondary, up to subordinate, gives AGP Type 1.
// - Bus below secondary or above subordinate gives hub link Type 1.
// - Byte, word, dword accesses allowed; address port only as dword.
// - Multi-byte fields are little-endian; low address holds low byte.
// - Address port is 32-bit read/write at 0CF8h, zero after reset.
// - Byte or word access to 0CF8h passes through as expansion I/O.
// - Address port bit 31 enables translation into config cycles.
// - Address port bits 30:24 are read-only zero.
// - Only the address/data port scheme, mechanism one, is offered.
// - Internal registers form three logical device register sets.
// - With enable set, data window accesses become config accesses.
// - Device 15:11, function 10:8, register 7:2; bits 1:0 reserved.
// - Internal devices answer only function zero; others master abort.
`timescale 1ns/1ps
`include "config_cycle_router_defines.svh"
module config_cycle_router
  import config_cycle_router_pkg::*;
#(
  parameter int ACK_TIMEOUT = `CCR_ACK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Host I/O request
  input  wire logic        io_req,
  input  wire logic        io_write,
  input  wire logic [15:0] io_addr,
  input  wire logic [3:0]  io_be,
  input  wire logic [31:0] io_wdata,
  // Host I/O answer
  output      logic        io_ready,
  output      logic        io_ack,
  output      logic        io_abort,
  output      logic [31:0] io_rdata,
  // Cycle fields shared by all targets
  output      logic [7:0]  cyc_bus,
  output      logic [4:0]  cyc_dev,
  output      logic [2:0]  cyc_func,
  output      logic [5:0]  cyc_reg,
  output      logic [3:0]  cyc_be,
  output      logic        cyc_write,
  output      logic [31:0] cyc_wdata,
  // Internal logical devices
  output      logic        int_req,
  output      logic [1:0]  int_dev,
  input  wire logic        int_ack,
  input  wire logic [31:0] int_rdata,
  // Hub link
  output      logic        hub_req,
  output      config_cycle_router_pkg::hub_kind_t hub_kind,
  output      logic [15:0] hub_addr,
  input  wire logic        hub_ack,
  input  wire logic        hub_abort,
  input  wire logic [31:0] hub_rdata,
  // AGP bridge
  output      logic        agp_req,
  output      logic        agp_type1,
  output      logic [15:0] agp_idsel,
  input  wire logic        agp_ack,
  input  wire logic        agp_abort,
  input  wire logic [31:0] agp_rdata,
  // Bus window of the AGP bridge
  input  wire logic [7:0]  sec_bus,
  input  wire logic [7:0]  sub_bus
);
  import config_cycle_router_pkg::*;

  localparam logic [10:0] TMO_LAST = 11'(ACK_TIMEOUT - 1);

  router_state_t s_reg;
  router_state_t s_next;

  target_t     dec_tgt;
  logic [31:0] resp_raw;
  logic [31:0] resp_masked;
  logic [31:0] port_masked;
  logic        hit_addr_port;
  logic        hit_data_win;
  logic        enabled;
  logic        far_ack;
  logic        far_abort;

  // Fields come straight from the held address port
  cfg_target_decode u_decode (
    .bus     (s_reg.addr_port[`CCR_BUS_HI:`CCR_BUS_LO]),
    .dev     (s_reg.addr_port[`CCR_DEV_HI:`CCR_DEV_LO]),
    .func    (s_reg.addr_port[`CCR_FUNC_HI:`CCR_FUNC_LO]),
    .sec_bus (sec_bus),
    .sub_bus (sub_bus),
    .tgt     (dec_tgt)
  );

  // Answer data of the side named by the held config target; plain I/O does not update it
  always_comb begin
    case (s_reg.tgt)
      TGT_INT:  resp_raw = int_rdata;
      TGT_AGP0: resp_raw = agp_rdata;
      TGT_AGP1: resp_raw = agp_rdata;
      default:  resp_raw = hub_rdata;
    endcase
  end

  // Only requested lanes reach the host
  lane_mask #(
    .LANES (4)
  ) u_resp_mask (
    .be   (s_reg.be),
    .din  (resp_raw),
    .dout (resp_masked)
  );

  lane_mask #(
    .LANES (4)
  ) u_port_mask (
    .be   (io_be),
    .din  (s_reg.addr_port),
    .dout (port_masked)
  );

  // Dword-aligned decode; byte lanes come from io_be
  assign hit_addr_port =
    io_addr[15:2] == 14'(`CCR_ADDR_PORT_IO >> 2);
  assign hit_data_win  =
    io_addr[15:2] == 14'(`CCR_DATA_WINDOW_IO >> 2);
  assign enabled       = s_reg.addr_port[`CCR_ENABLE_BIT];

  assign far_ack = (s_reg.int_req & int_ack) |
                   (s_reg.hub_req & hub_ack) |
                   (s_reg.agp_req & agp_ack);
  assign far_abort = (s_reg.hub_req & hub_abort) |
                     (s_reg.agp_req & agp_abort);

  always_comb begin
    s_next        = s_reg;
    s_next.io_ack = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.io_rdy = 1'b1;
        if (io_req) begin
          s_next.be       = io_be;
          s_next.wr       = io_write;
          s_next.wdata    = io_wdata;
          s_next.io_abort = 1'b0;
          s_next.tmo      = '0;
          if (hit_addr_port && io_be == `CCR_FULL_DWORD) begin
            // Only a whole dword touches the address port
            if (io_write) begin
              s_next.addr_port = io_wdata & `CCR_ADDR_WR_MASK;
            end
            s_next.io_rdata = port_masked;
            s_next.io_ack   = 1'b1;
          end else if (hit_data_win && enabled) begin
            // Address port decode into a config cycle
            s_next.bus  = s_reg.addr_port[`CCR_BUS_HI:`CCR_BUS_LO];
            s_next.dev  = s_reg.addr_port[`CCR_DEV_HI:`CCR_DEV_LO];
            s_next.func = s_reg.addr_port[`CCR_FUNC_HI:`CCR_FUNC_LO];
            s_next.regn = s_reg.addr_port[`CCR_REG_HI:`CCR_REG_LO];
            s_next.tgt  = dec_tgt;
            case (dec_tgt)
              TGT_INT: begin
                // Confined to the chip; hub link stays quiet
                s_next.int_req = 1'b1;
                s_next.int_dev =
                  s_reg.addr_port[`CCR_DEV_LO+1:`CCR_DEV_LO];
                s_next.io_rdy  = 1'b0;
                s_next.st      = ST_BUSY;
              end
              TGT_HUB0: begin
                s_next.hub_req  = 1'b1;
                s_next.hub_kind = HUB_CFG0;
                s_next.io_rdy   = 1'b0;
                s_next.st       = ST_BUSY;
              end
              TGT_HUB1: begin
                s_next.hub_req  = 1'b1;
                s_next.hub_kind = HUB_CFG1;
                s_next.io_rdy   = 1'b0;
                s_next.st       = ST_BUSY;
              end
              TGT_AGP0: begin
                // Device 16 and up selects no line; the bridge aborts
                s_next.agp_req   = 1'b1;
                s_next.agp_type1 = 1'b0;
                s_next.agp_idsel =
                  s_reg.addr_port[`CCR_DEV_HI] ? 16'h0000 :
                  16'h0001 << s_reg.addr_port[`CCR_DEV_HI-1:`CCR_DEV_LO];
                s_next.io_rdy    = 1'b0;
                s_next.st        = ST_BUSY;
              end
              TGT_AGP1: begin
                s_next.agp_req   = 1'b1;
                s_next.agp_type1 = 1'b1;
                s_next.agp_idsel = 16'h0000;
                s_next.io_rdy    = 1'b0;
                s_next.st        = ST_BUSY;
              end
              default: begin
                // Nonzero function on an internal device
                s_next.io_abort = 1'b1;
                s_next.io_rdata = `CCR_ABORT_DATA;
                s_next.io_ack   = 1'b1;
              end
            endcase
          end else begin
            // Everything else, including a disabled window, is plain I/O
            s_next.hub_req  = 1'b1;
            s_next.hub_kind = HUB_IO;
            s_next.hub_addr = io_addr;
            s_next.io_rdy   = 1'b0;
            s_next.st       = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        s_next.tmo = s_reg.tmo + 11'h001;
        if (far_ack) begin
          s_next.int_req  = 1'b0;
          s_next.hub_req  = 1'b0;
          s_next.agp_req  = 1'b0;
          s_next.io_abort = far_abort;
          s_next.io_rdata = far_abort ? `CCR_ABORT_DATA : resp_masked;
          s_next.io_ack   = 1'b1;
          s_next.io_rdy   = 1'b1;
          s_next.st       = ST_IDLE;
        end else if (s_reg.tmo == TMO_LAST) begin
          // A silent far side must not hang the host forever
          s_next.int_req  = 1'b0;
          s_next.hub_req  = 1'b0;
          s_next.agp_req  = 1'b0;
          s_next.io_abort = 1'b1;
          s_next.io_rdata = `CCR_ABORT_DATA;
          s_next.io_ack   = 1'b1;
          s_next.io_rdy   = 1'b1;
          s_next.st       = ST_IDLE;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg           <= '0;
      s_reg.addr_port <= `CCR_ADDR_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every output is a field of the registered state
  assign io_ready  = s_reg.io_rdy;
  assign io_ack    = s_reg.io_ack;
  assign io_abort  = s_reg.io_abort;
  assign io_rdata  = s_reg.io_rdata;
  assign cyc_bus   = s_reg.bus;
  assign cyc_dev   = s_reg.dev;
  assign cyc_func  = s_reg.func;
  assign cyc_reg   = s_reg.regn;
  assign cyc_be    = s_reg.be;
  assign cyc_write = s_reg.wr;
  assign cyc_wdata = s_reg.wdata;
  assign int_req   = s_reg.int_req;
  assign int_dev   = s_reg.int_dev;
  assign hub_req   = s_reg.hub_req;
  assign hub_kind  = s_reg.hub_kind;
  assign hub_addr  = s_reg.hub_addr;
  assign agp_req   = s_reg.agp_req;
  assign agp_type1 = s_reg.agp_type1;
  assign agp_idsel = s_reg.agp_idsel;

endmodule

// File: verification/config_cycle_router_assertions.sv
// Checker for the router's host and far-side handshakes.
// Assumes one request at a time and one-cycle acks from the far sides.
`timescale 1ns/1ps
`include "config_cycle_router_defines.svh"
module ccr_checker
  import config_cycle_router_pkg::*;
#(
  parameter int ACK_TIMEOUT = `CCR_ACK_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Host side
  input wire logic        io_req,
  input wire logic        io_write,
  input wire logic [15:0] io_addr,
  input wire logic [3:0]  io_be,
  input wire logic        io_ready,
  input wire logic        io_ack,
  input wire logic        io_abort,
  input wire logic [31:0] io_rdata,
  // Far sides
  input wire logic        int_req,
  input wire logic        int_ack,
  input wire logic        hub_req,
  input wire config_cycle_router_pkg::hub_kind_t hub_kind,
  input wire logic        hub_ack,
  input wire logic        agp_req,
  input wire logic        agp_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  localparam logic [10:0] TMO_LAST = 11'(ACK_TIMEOUT - 1);
  logic        port;
  logic [10:0] wait_cnt;
  assign port = io_req && io_ready && io_addr == 16'h0cf8;

  // Cycles a far request has stood; a silent side is cut off at the last
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt <= 11'h000;
    end else if (int_req || hub_req || agp_req) begin
      wait_cnt <= wait_cnt + 11'h001;
    end else begin
      wait_cnt <= 11'h000;
    end
  end

  AST_PORT_DONE: assert property (port && io_be == 4'hf |=> io_ack)
    else $error("address port access not answered next cycle");
  AST_PORT_ZERO: assert property (port && io_be == 4'hf && !io_write
    |=> io_rdata[30:24] == 7'h00 && io_rdata[1:0] == 2'h0)
    else $error("reserved address port bits read nonzero");
  AST_PASS_IO: assert property (port && io_be != 4'hf
    |=> hub_req && hub_kind == HUB_IO && !io_ack)
    else $error("partial address port access not passed through");
  AST_INT_LOCAL: assert property (int_req |-> !hub_req && !agp_req)
    else $error("internal cycle seen on another side");
  AST_HUB_HOLD: assert property (hub_req && !hub_ack
    && wait_cnt != TMO_LAST |=> hub_req)
    else $error("hub request dropped before ack");
  AST_HUB_TMO: assert property (hub_req && !hub_ack
    && wait_cnt == TMO_LAST |=> !hub_req && io_ack && io_abort)
    else $error("silent hub link not cut off with an abort");
  AST_HUB_END: assert property (hub_req && hub_ack |=> !hub_req && io_ack)
    else $error("hub ack not turned into completion");
  AST_AGP_END: assert property (agp_req && agp_ack |=> !agp_req && io_ack)
    else $error("agp ack not turned into completion");
  AST_INT_END: assert property (int_req && int_ack |=> !int_req && io_ack)
    else $error("internal ack not turned into completion");
  AST_BUSY: assert property (hub_req || int_req || agp_req |-> !io_ready)
    else $error("ready while a cycle is outstanding");
  AST_ABORT_ONES: assert property (io_ack && io_abort
    |-> io_rdata == 32'hffff_ffff)
    else $error("abort without all-ones data");

  cover property (hub_req && hub_kind == HUB_CFG1);
  cover property (int_req && int_ack);
  cover property (io_ack && io_abort);
  cover property (hub_req && wait_cnt == TMO_LAST);
endmodule

bind config_cycle_router ccr_checker #(.ACK_TIMEOUT(ACK_TIMEOUT)) chk_i (
  .clk, .sys_rst, .io_req,
  .io_write, .io_addr, .io_be, .io_ready, .io_ack, .io_abort, .io_rdata,
  .int_req, .int_ack, .hub_req, .hub_kind, .hub_ack, .agp_req, .agp_ack);

// File: verification/far_side_model.sv
// Far-side model: answers a held request after a set delay.
// Assumes the requester holds req until it samples ack.
`timescale 1ns/1ps
module far_side_model (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Request and settings
  input wire logic        req,
  input wire logic [7:0]  dly,
  input wire logic        fail,
  input wire logic [31:0] data,
  // Answer
  output     logic        ack,
  output     logic        abort,
  output     logic [31:0] rdata
);
  logic [7:0] wait_reg;
  // Inverted data outside the answer so stale values never match
  assign rdata = ack ? data : ~data;
  assign abort = ack && fail;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack      <= 1'b0;
      wait_reg <= 8'h00;
    end else begin
      ack      <= req && !ack && wait_reg == dly;
      wait_reg <= (req && !ack) ? wait_reg + 8'h01 : 8'h00;
    end
  end
endmodule

// File: verification/config_cycle_router_bench.sv
// Bench for the config cycle router: routing table, port, aborts.
// Assumes far_side_model for all three far sides.
`timescale 1ns/1ps
module config_cycle_router_bench;
  import config_cycle_router_pkg::*;
  localparam logic [31:0] DAT = 32'h8765_4321;
  logic clk = 1'b0, sys_rst = 1'b1, io_req = 1'b0, io_write = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [3:0]  io_be = 4'h0, seen = 4'h0;
  logic [31:0] io_wdata = 32'h0, rd, io_rdata, int_rdata, hub_rdata;
  logic [31:0] agp_rdata;
  logic [7:0]  dly = 8'h00, cyc_bus;
  logic [4:0]  cyc_dev;
  logic [2:0]  cyc_func;
  logic [5:0]  cyc_reg;
  logic [21:0] cap;
  logic [1:0]  int_dev;
  logic fail = 1'b0, ab, io_ready, io_ack, io_abort, int_req, int_ack;
  logic hub_req, hub_ack, hub_abort, agp_req, agp_type1, agp_ack;
  logic agp_abort, cyc_write;
  logic [3:0]  cyc_be;
  logic [4:0]  bcap;
  logic [31:0] cyc_wdata, wcap;
  logic [15:0] hub_addr, agp_idsel, haddr, idsel;
  hub_kind_t hub_kind;
  int bad_count = 0, total_checks = 0;
  // Row: address port value, seen code, abort
  logic [36:0] rows [13] = '{
    {32'h8000_0004, 4'h8, 1'b0}, {32'h8000_0800, 4'h9, 1'b0},
    {32'h8000_10fc, 4'ha, 1'b0}, {32'h8000_1808, 4'h5, 1'b0},
    {32'h8000_f800, 4'h5, 1'b0}, {32'h8000_0100, 4'h0, 1'b1},
    {32'h8000_1700, 4'h0, 1'b1}, {32'h8000_1900, 4'h5, 1'b0},
    {32'h8005_0000, 4'hc, 1'b0}, {32'h8006_0000, 4'hd, 1'b0},
    {32'h8008_ff00, 4'hd, 1'b0}, {32'h8004_0000, 4'h6, 1'b0},
    {32'h80ff_0000, 4'h6, 1'b0}};

  config_cycle_router #(.ACK_TIMEOUT(16)) uut (.clk, .sys_rst, .io_req,
    .io_write, .io_addr, .io_be, .io_wdata, .io_ready, .io_ack,
    .io_abort, .io_rdata, .cyc_bus, .cyc_dev, .cyc_func, .cyc_reg,
    .cyc_be, .cyc_write, .cyc_wdata, .int_req, .int_dev, .int_ack,
    .int_rdata, .hub_req, .hub_kind, .hub_addr, .hub_ack, .hub_abort,
    .hub_rdata, .agp_req, .agp_type1, .agp_idsel, .agp_ack,
    .agp_abort, .agp_rdata, .sec_bus(8'h05), .sub_bus(8'h08));
  far_side_model int_m (.clk, .sys_rst, .req(int_req), .dly, .fail,
    .data(DAT), .ack(int_ack), .abort(), .rdata(int_rdata));
  far_side_model hub_m (.clk, .sys_rst, .req(hub_req), .dly, .fail,
    .data(DAT), .ack(hub_ack), .abort(hub_abort), .rdata(hub_rdata));
  far_side_model agp_m (.clk, .sys_rst, .req(agp_req), .dly, .fail,
    .data(DAT), .ack(agp_ack), .abort(agp_abort), .rdata(agp_rdata));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (int_req) seen <= {2'b10, int_dev};
    if (hub_req) seen <= {2'b01, hub_kind};
    if (agp_req) seen <= {3'b110, agp_type1};
    if (hub_req) haddr <= hub_addr;
    if (agp_req) idsel <= agp_idsel;
    if (int_req || hub_req || agp_req) begin
      cap  <= {cyc_bus, cyc_dev, cyc_func, cyc_reg};
      wcap <= cyc_wdata;
      bcap <= {cyc_write, cyc_be};
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic io(input logic w, input logic [15:0] a,
                    input logic [3:0] be, input logic [31:0] d);
    int n;
    n = 0;
    while (io_ready !== 1'b1) @(posedge clk);
    seen = 4'h0;
    io_req   <= 1'b1;
    io_write <= w;
    io_addr  <= a;
    io_be    <= be;
    io_wdata <= d;
    @(posedge clk);
    io_req <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (io_ack !== 1'b1 && n < 64);
    rd = io_rdata;
    ab = io_abort;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // About 40 accesses of under 30 cycles each; generous margin
  initial begin
    #50us;
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      dly <= 8'(i % 3);
      io(1'b1, 16'h0cf8, 4'hf, rows[i][36:5]);
      io(1'b0, 16'h0cfc, 4'hf, 32'h0);
      chk(seen, rows[i][4:1]);
      chk(ab, rows[i][0]);
      chk(rd, rows[i][0] ? 32'hffff_ffff : DAT);
      if (!rows[i][0]) chk(cap, {rows[i][28:13], rows[i][12:7]});
      $display("row %0d done", i);
    end
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    chk(rd, 32'h0);
    io(1'b1, 16'h0cf8, 4'hf, 32'hffff_ffff);
    io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    chk(rd, 32'h80ff_fffc);
    io(1'b1, 16'h0cf8, 4'h1, 32'h0);
    chk(seen, 4'h4);
    chk(haddr, 16'h0cf8);
    io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    chk(rd, 32'h80ff_fffc);
    $display("address port test done");
    io(1'b1, 16'h0cf8, 4'hf, 32'h0000_1800);
    io(1'b0, 16'h0cfc, 4'hf, 32'h0);
    chk(seen, 4'h4);
    io(1'b1, 16'h0cf8, 4'hf, 32'h8000_0000);
    io(1'b0, 16'h0cfc, 4'h2, 32'h0);
    chk(rd, DAT & 32'h0000_ff00);
    io(1'b1, 16'h0cfc, 4'hc, 32'hcafe_f00d);
    chk(wcap, 32'hcafe_f00d);
    chk(bcap, 5'h1c);
    io(1'b1, 16'h0cf8, 4'hf, 32'h8005_2000);
    io(1'b0, 16'h0cfc, 4'hf, 32'h0);
    chk(idsel, 16'h0010);
    $display("enable and lane test done");
    io(1'b1, 16'h0cf8, 4'hf, 32'h8000_1800);
    fail <= 1'b1;
    io(1'b0, 16'h0cfc, 4'hf, 32'h0);
    chk(ab, 1'b1);
    fail <= 1'b0;
    dly  <= 8'hff;
    io(1'b0, 16'h0cfc, 4'hf, 32'h0);
    chk(rd, 32'hffff_ffff);
    chk(ab, 1'b1);
    $display("abort and timeout test done");
    give_verdict();
  end
endmodule
